// ### design/byte_serializer.sv
`default_nettype none
module byte_serializer (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // Packed pixel bytes
   byte_pack_if.dst                      pk,
   // Byte stream
   output logic [pixfmt_pkg::BYTE_W-1:0] out_byte,
   output logic                          out_valid,
   input  wire logic                     out_ready
);
   import pixfmt_pkg::*;

   typedef struct packed {
      logic [PACK_W-1:0] shift;
      logic [CNT_W-1:0]  left;
   } state_type;

   state_type st_q;
   state_type st_d;

   // Accept a new group when empty or as the last byte leaves, so no cycle is lost
   assign pk.ready  = (st_q.left == BYTES_NONE) || ((st_q.left == BYTES_ONE) && out_ready);
   assign out_valid = (st_q.left != BYTES_NONE);
   assign out_byte  = st_q.shift[BYTE_W-1:0];

   // Lowest byte first
   always_comb begin
      st_d = st_q;
      if (out_valid && out_ready) begin
         st_d.shift = st_q.shift >> BYTE_W;
         st_d.left  = st_q.left - BYTES_ONE;
      end
      if (pk.valid && pk.ready) begin
         st_d.shift = pk.bytes;
         st_d.left  = pk.count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // byte_serializer
`default_nettype wire

// ### design/pixel_binning_output_formatter.sv
// Function
// - Binning digitally sums converted samples
// - Vertical sum per column; height, row start divided
// - Horizontal sum per line; width divided
// - Horizontal factor reduces column start and width
// - Vertical factor reduces height and height step
// - Binned sizes truncate, remainder dropped
// - Both factors together shrink both dimensions
// - Colour sensors sum same filter positions only
// - Formats allowed by sensor type and mode
// - Byte luma sends eight most significant bits
// - Word luma left aligned, low byte first
// - Colour formats demosaic the Bayer samples
// - RGB sends three bytes per pixel
// - 4:2:2 sends two luma, two shared chroma
// - Raw formats bypass processing, same layouts
// - Full width kept, truncated at output
// - Converter width taken only while stopped
// - Width change recomputes minimum packet size; maximum fixed
// - Raw mode disables processing chain
// - Video mode taken only while stopped
`default_nettype none
module pixel_binning_output_formatter #(
   parameter int LINE_MAX        = 4096,
   parameter int PKT_UNIT_BYTES  = 1024,
   parameter int LINES_UF_NUM    = 256,
   parameter int PKT_MAX         = 48
) (
   // Clock and reset
   input wire logic                         sys_clk,
   input wire logic                         rst,
   // Sensor samples
   input wire logic [pixfmt_pkg::OUT_W-1:0] pix_sample,
   input wire logic                         pix_valid,
   input wire logic                         pix_frame_start,
   input wire logic                         pix_line_end,
   output logic                             pix_ready,
   // Configuration
   input wire logic                         acquire,
   input wire logic                         colour_sensor,
   input wire pixfmt_pkg::video_mode_type    video_mode,
   input wire pixfmt_pkg::pixel_format_type pixel_format,
   input wire logic [pixfmt_pkg::CW_W-1:0]  converter_sample_width,
   input wire logic [pixfmt_pkg::BIN_W-1:0] horizontal_bin_factor,
   input wire logic [pixfmt_pkg::BIN_W-1:0] vertical_bin_factor,
   input wire logic [pixfmt_pkg::ROI_W-1:0] roi_start_col,
   input wire logic [pixfmt_pkg::ROI_W-1:0] roi_width,
   input wire logic [pixfmt_pkg::ROI_W-1:0] roi_start_row,
   input wire logic [pixfmt_pkg::ROI_W-1:0] roi_height,
   input wire logic [pixfmt_pkg::ROI_W-1:0] roi_height_step,
   // Binned geometry
   output logic [pixfmt_pkg::ROI_W-1:0]     roi_start_col_binned,
   output logic [pixfmt_pkg::ROI_W-1:0]     roi_width_binned,
   output logic [pixfmt_pkg::ROI_W-1:0]     roi_start_row_binned,
   output logic [pixfmt_pkg::ROI_W-1:0]     roi_height_binned,
   output logic [pixfmt_pkg::ROI_W-1:0]     roi_height_step_binned,
   // Status
   output logic                             format_error,
   output logic                             config_ignored,
   output logic [pixfmt_pkg::PKT_W-1:0]     packet_size_min,
   output logic [pixfmt_pkg::PKT_W-1:0]     packet_size_max,
   output logic                             packet_limits_update,
   // Byte stream toward the host link
   output logic [pixfmt_pkg::BYTE_W-1:0]    out_byte,
   output logic                             out_valid,
   input wire logic                         out_ready
);
   import pixfmt_pkg::*;

   localparam int ADDR_W = $clog2(LINE_MAX);
   localparam int HI     = OUT_W - 1;

   typedef struct packed {
      logic [CW_W-1:0]       cw;
      video_mode_type        mode;
      pixel_format_type      fmt;
      logic [BIN_W-1:0]      hbf;
      logic [BIN_W-1:0]      vbf;
      logic [3:0]            hpos;
      logic [3:0]            vpos;
      logic [ADDR_W-1:0]     ocol;
      logic                  brow;
      logic [1:0][OUT_W-1:0] hacc;
      logic [OUT_W-1:0]      prev_left;
      logic [OUT_W-1:0]      cur_left;
      logic [OUT_W-1:0]      y0;
      logic [OUT_W-1:0]      u0;
      logic [OUT_W-1:0]      v0;
      logic                  fmt_err;
      logic                  ignored;
      logic [PKT_W-1:0]      pkt_min;
      logic                  pkt_upd;
   } state_type;

   state_type st_q;
   state_type st_d;

   // Two banks so that colour rows of both Bayer parities keep partial sums
   logic [OUT_W-1:0] bin_mem  [2*LINE_MAX];
   logic [OUT_W-1:0] prev_mem [LINE_MAX];

   byte_pack_if pk ();

   logic [CW_W-1:0]   cw_in;
   logic [BIN_W-1:0]  hbf_in;
   logic [BIN_W-1:0]  vbf_in;
   logic [3:0]        stride;
   logic [3:0]        hgrp;
   logic [3:0]        vgrp;
   logic [3:0]        h_e;
   logic [3:0]        v_e;
   logic [ADDR_W-1:0] col_e;
   logic              brow_e;
   logic              hidx;
   logic              vpar;
   logic              hfirst;
   logic              vfirst;
   logic              hdone;
   logic              vdone;
   logic              take;
   logic              bin_out;
   logic              fmt_ok;
   logic              bin_we;
   logic              prev_we;
   logic [ADDR_W:0]   bin_addr;
   logic [OUT_W-1:0]  aligned;
   logic [OUT_W-1:0]  hsum;
   logic [OUT_W-1:0]  vsum;
   logic [OUT_W-1:0]  mem_rd;
   logic [OUT_W-1:0]  prev_rd;
   logic [OUT_W-1:0]  r_c;
   logic [OUT_W-1:0]  g_c;
   logic [OUT_W-1:0]  b_c;
   logic [OUT_W-1:0]  y_c;
   logic [OUT_W-1:0]  u_c;
   logic [OUT_W-1:0]  v_c;
   logic [OUT_W-1:0]  luma;
   logic [OUT_W:0]    g_ad;
   logic [OUT_W:0]    g_bc;
   logic [OUT_W+2:0]  ysum;
   logic [OUT_W:0]    usum;
   logic [OUT_W:0]    vsum2;
   logic [OUT_W:0]    uavg;
   logic [OUT_W:0]    vavg;
   logic [31:0]       pk_num;
   logic [31:0]       pk_den;
   logic [31:0]       pk_min;
   logic [PKT_W-1:0]  pkt_min_d;

   assign bin_addr = {vpar, col_e};
   assign mem_rd   = bin_mem[bin_addr];
   assign prev_rd  = prev_mem[col_e];

   always_comb begin
      st_d      = st_q;
      pk.valid  = 1'b0;
      pk.bytes  = '0;
      pk.count  = BYTES_NONE;
      bin_we    = 1'b0;
      prev_we   = 1'b0;
      // Out-of-range widths fall back to the full sample width
      cw_in  = ((converter_sample_width == CW_NONE) || (converter_sample_width > CW_FULL))
               ? CW_FULL : converter_sample_width;
      hbf_in = (horizontal_bin_factor == BIN_NONE) ? BIN_ONE : horizontal_bin_factor;
      vbf_in = (vertical_bin_factor == BIN_NONE) ? BIN_ONE : vertical_bin_factor;

      if (!acquire) begin
         st_d.cw   = cw_in;
         st_d.mode = video_mode;
         st_d.fmt  = pixel_format;
         st_d.hbf  = hbf_in;
         st_d.vbf  = vbf_in;
      end
      st_d.ignored = acquire && ((cw_in != st_q.cw) || (video_mode != st_q.mode)
                                 || (pixel_format != st_q.fmt) || (hbf_in != st_q.hbf)
                                 || (vbf_in != st_q.vbf));
      fmt_ok       = format_allowed(st_q.fmt, st_q.mode, colour_sensor);
      st_d.fmt_err = !fmt_ok;

      // Samples are left aligned on entry so sums saturate at full scale
      aligned = pix_sample << (CW_FULL - st_q.cw);
      take    = pix_valid && pk.ready;

      h_e    = pix_frame_start ? 4'h0 : st_q.hpos;
      v_e    = pix_frame_start ? 4'h0 : st_q.vpos;
      col_e  = pix_frame_start ? '0 : st_q.ocol;
      brow_e = pix_frame_start ? 1'b0 : st_q.brow;

      // Same filter colours sit two apart on a Bayer sensor
      stride = colour_sensor ? 4'h2 : 4'h1;
      hgrp   = stride * {1'b0, st_q.hbf};
      vgrp   = stride * {1'b0, st_q.vbf};
      hidx   = colour_sensor & h_e[0];
      vpar   = colour_sensor & v_e[0];
      hfirst = (h_e < stride);
      vfirst = (v_e < stride);
      hdone  = (h_e >= (hgrp - stride));
      vdone  = (v_e >= (vgrp - stride));

      hsum    = sat_add(hfirst ? PIX_ZERO : st_q.hacc[hidx], aligned);
      vsum    = sat_add(vfirst ? PIX_ZERO : mem_rd, hsum);
      bin_we  = take && hdone;
      bin_out = take && hdone && vdone;
      prev_we = bin_out;

      if (take) begin
         st_d.hacc[hidx] = hsum;
         st_d.vpos       = v_e;
         st_d.brow       = brow_e;
         st_d.ocol       = hdone ? col_e + 1'b1 : col_e;
         st_d.hpos       = (h_e == (hgrp - 4'h1)) ? 4'h0 : h_e + 4'h1;
         if (pix_line_end) begin
            // A partial group at the line end is dropped
            st_d.hpos = 4'h0;
            st_d.ocol = '0;
            st_d.vpos = (v_e == (vgrp - 4'h1)) ? 4'h0 : v_e + 4'h1;
            st_d.brow = vdone ? ~brow_e : brow_e;
         end
         if (bin_out) begin
            st_d.prev_left = prev_rd;
            st_d.cur_left  = vsum;
         end
      end

      // Nearest neighbour 2x2 demosaic; first row and column see stale neighbours
      g_ad = {1'b0, st_q.prev_left} + {1'b0, vsum};
      g_bc = {1'b0, prev_rd} + {1'b0, st_q.cur_left};
      case ({brow_e, col_e[0]})
         2'b00: begin
            r_c = vsum;
            b_c = st_q.prev_left;
            g_c = g_bc[OUT_W:1];
         end
         2'b01: begin
            r_c = st_q.cur_left;
            b_c = prev_rd;
            g_c = g_ad[OUT_W:1];
         end
         2'b10: begin
            r_c = prev_rd;
            b_c = st_q.cur_left;
            g_c = g_ad[OUT_W:1];
         end
         default: begin
            r_c = st_q.prev_left;
            b_c = vsum;
            g_c = g_bc[OUT_W:1];
         end
      endcase

      ysum  = ({3'b0, r_c} << 1) + ({3'b0, g_c} << 2) + {3'b0, g_c} + {3'b0, b_c};
      y_c   = ysum[OUT_W+2:3];
      usum  = {1'b0, b_c} + {1'b1, PIX_ZERO} - {1'b0, y_c};
      vsum2 = {1'b0, r_c} + {1'b1, PIX_ZERO} - {1'b0, y_c};
      u_c   = usum[OUT_W:1];
      v_c   = vsum2[OUT_W:1];
      uavg  = {1'b0, st_q.u0} + {1'b0, u_c};
      vavg  = {1'b0, st_q.v0} + {1'b0, v_c};
      luma  = colour_sensor ? y_c : vsum;

      // Truncation to the output width happens only here
      if (bin_out && fmt_ok) begin
         case (st_q.fmt)
            luma_byte_format: begin
               pk.valid = 1'b1;
               pk.count = BYTES_ONE;
               pk.bytes = {24'h000000, luma[HI -: BYTE_W]};
            end
            raw_byte_format: begin
               pk.valid = 1'b1;
               pk.count = BYTES_ONE;
               pk.bytes = {24'h000000, vsum[HI -: BYTE_W]};
            end
            luma_word_format: begin
               pk.valid = 1'b1;
               pk.count = BYTES_TWO;
               pk.bytes = {16'h0000, luma};
            end
            raw_word_format: begin
               pk.valid = 1'b1;
               pk.count = BYTES_TWO;
               pk.bytes = {16'h0000, vsum};
            end
            rgb_triple_format: begin
               pk.valid = 1'b1;
               pk.count = BYTES_THREE;
               pk.bytes = {8'h00, b_c[HI -: BYTE_W], g_c[HI -: BYTE_W], r_c[HI -: BYTE_W]};
            end
            yuv_pair_format: begin
               if (!col_e[0]) begin
                  st_d.y0 = y_c;
                  st_d.u0 = u_c;
                  st_d.v0 = v_c;
               end else begin
                  pk.valid = 1'b1;
                  pk.count = BYTES_FOUR;
                  pk.bytes = {vavg[OUT_W -: BYTE_W], y_c[HI -: BYTE_W],
                              uavg[OUT_W -: BYTE_W], st_q.y0[HI -: BYTE_W]};
               end
            end
            default: begin
               pk.valid = 1'b0;
            end
         endcase
      end

      // Lines per micro-frame shrink as conversion takes longer at wider samples
      pk_num    = 32'(roi_width_binned) * 32'(format_bytes(st_q.fmt)) * 32'(LINES_UF_NUM);
      pk_den    = 32'(st_q.cw) * 32'(PKT_UNIT_BYTES);
      pk_min    = (pk_num + pk_den - 32'h1) / pk_den;
      pkt_min_d = (pk_min > 32'(PKT_MAX)) ? PKT_W'(PKT_MAX) : pk_min[PKT_W-1:0];
      st_d.pkt_min = pkt_min_d;
      st_d.pkt_upd = (pkt_min_d != st_q.pkt_min);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q     <= '0;
         st_q.cw  <= CW_FULL;
         st_q.hbf <= BIN_ONE;
         st_q.vbf <= BIN_ONE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (bin_we) begin
         bin_mem[bin_addr] <= vsum;
      end
      if (prev_we) begin
         prev_mem[col_e] <= vsum;
      end
   end

   roi_scaler #(.W(ROI_W)) u_start_col (.sys_clk, .rst, .value(roi_start_col), .factor(st_q.hbf),
      .value_binned(roi_start_col_binned));
   roi_scaler #(.W(ROI_W)) u_width (.sys_clk, .rst, .value(roi_width), .factor(st_q.hbf),
      .value_binned(roi_width_binned));
   roi_scaler #(.W(ROI_W)) u_start_row (.sys_clk, .rst, .value(roi_start_row), .factor(st_q.vbf),
      .value_binned(roi_start_row_binned));
   roi_scaler #(.W(ROI_W)) u_height (.sys_clk, .rst, .value(roi_height), .factor(st_q.vbf),
      .value_binned(roi_height_binned));
   roi_scaler #(.W(ROI_W)) u_height_step (.sys_clk, .rst, .value(roi_height_step), .factor(st_q.vbf),
      .value_binned(roi_height_step_binned));

   byte_serializer u_ser (.sys_clk, .rst, .pk(pk.dst), .out_byte, .out_valid, .out_ready);

   assign pix_ready            = pk.ready;
   assign format_error         = st_q.fmt_err;
   assign config_ignored       = st_q.ignored;
   assign packet_size_min      = st_q.pkt_min;
   assign packet_size_max      = PKT_W'(PKT_MAX);
   assign packet_limits_update = st_q.pkt_upd;
endmodule // pixel_binning_output_formatter
`default_nettype wire

// ### design/roi_scaler.sv
`default_nettype none
module roi_scaler #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Setting and factor
   input  wire logic [W-1:0]               value,
   input  wire logic [pixfmt_pkg::BIN_W-1:0] factor,
   // Reduced setting
   output logic [W-1:0]                    value_binned
);
   import pixfmt_pkg::*;

   typedef struct packed {
      logic [W-1:0] scaled;
   } state_type;

   state_type             st_q;
   state_type             st_d;
   logic [BIN_W-1:0]      div;

   // Integer division drops the remainder
   always_comb begin
      div = (factor == BIN_NONE) ? BIN_ONE : factor;
      st_d = st_q;
      st_d.scaled = value / W'(div);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign value_binned = st_q.scaled;
endmodule // roi_scaler
`default_nettype wire

// ### include/byte_pack_if.sv
`default_nettype none
interface byte_pack_if;
   import pixfmt_pkg::*;
   logic [PACK_W-1:0] bytes;
   logic [CNT_W-1:0]  count;
   logic              valid;
   logic              ready;
   modport src (output bytes, output count, output valid, input ready);
   modport dst (input bytes, input count, input valid, output ready);
endinterface
`default_nettype wire

// ### include/pixfmt_pkg.sv
`default_nettype none
package pixfmt_pkg;

   localparam int OUT_W  = 16;
   localparam int BYTE_W = 8;
   localparam int CW_W   = 5;
   localparam int BIN_W  = 3;
   localparam int FMT_W  = 3;
   localparam int ROI_W  = 14;
   localparam int PKT_W  = 16;
   localparam int CNT_W  = 3;
   localparam int PACK_W = 4 * BYTE_W;

   localparam logic [CW_W-1:0]  CW_FULL  = 5'h10;
   localparam logic [CW_W-1:0]  CW_NONE  = 5'h00;
   localparam logic [BIN_W-1:0] BIN_ONE  = 3'h1;
   localparam logic [BIN_W-1:0] BIN_NONE = 3'h0;
   localparam logic [OUT_W-1:0] PIX_MAX  = 16'hffff;
   localparam logic [OUT_W-1:0] PIX_ZERO = 16'h0000;

   localparam logic [CNT_W-1:0] BYTES_NONE  = 3'h0;
   localparam logic [CNT_W-1:0] BYTES_ONE   = 3'h1;
   localparam logic [CNT_W-1:0] BYTES_TWO   = 3'h2;
   localparam logic [CNT_W-1:0] BYTES_THREE = 3'h3;
   localparam logic [CNT_W-1:0] BYTES_FOUR  = 3'h4;

   typedef enum logic [FMT_W-1:0] {
      luma_byte_format  = 3'h0,
      luma_word_format  = 3'h1,
      yuv_pair_format   = 3'h2,
      rgb_triple_format = 3'h3,
      raw_byte_format   = 3'h4,
      raw_word_format   = 3'h5
   } pixel_format_type;

   typedef enum logic {
      mode_normal = 1'b0,
      mode_raw    = 1'b1
   } video_mode_type;

   function automatic logic format_allowed(pixel_format_type f, video_mode_type m, logic colour);
      case (f)
         luma_byte_format:  return (m == mode_normal) && !colour;
         luma_word_format:  return (m == mode_normal);
         yuv_pair_format:   return (m == mode_normal) && colour;
         rgb_triple_format: return (m == mode_normal) && colour;
         raw_byte_format:   return (m == mode_raw) && !colour;
         raw_word_format:   return (m == mode_raw);
         default:           return 1'b0;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] format_bytes(pixel_format_type f);
      case (f)
         luma_byte_format, raw_byte_format: return BYTES_ONE;
         rgb_triple_format:                 return BYTES_THREE;
         default:                           return BYTES_TWO;
      endcase
   endfunction

   function automatic logic [OUT_W-1:0] sat_add(logic [OUT_W-1:0] a, logic [OUT_W-1:0] b);
      logic [OUT_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[OUT_W] ? PIX_MAX : s[OUT_W-1:0];
   endfunction

endpackage
`default_nettype wire

// ### tb/pixel_binning_output_formatter_assertions.sv
`default_nettype none
module pbof_checker #(
   parameter int PKT_MAX = 48
) (
   // Clock, reset and settings
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        acquire,
   input wire logic        video_mode,
   input wire logic [2:0]  horizontal_bin_factor,
   input wire logic [2:0]  vertical_bin_factor,
   input wire logic [13:0] roi_width,
   input wire logic [13:0] roi_start_row,
   // Watched outputs and out_ready
   input wire logic [13:0] roi_width_binned,
   input wire logic [13:0] roi_start_row_binned,
   input wire logic        config_ignored,
   input wire logic [15:0] packet_size_min,
   input wire logic [15:0] packet_size_max,
   input wire logic        pix_ready,
   input wire logic [7:0]  out_byte,
   input wire logic        out_valid,
   input wire logic        out_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   import pixfmt_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   function automatic logic [13:0] dv(logic [13:0] v, logic [2:0] f);
      return v / ((f == 3'h0) ? 14'h1 : {11'h0, f});
   endfunction
   // Factors act one edge after latching
   sequence s_steady;
      (!rst && !acquire && $stable(horizontal_bin_factor) && $stable(vertical_bin_factor))[*3];
   endsequence
   sequence s_mode_moved;
      !acquire ##1 (acquire && $stable(video_mode)) ##1 (acquire && $changed(video_mode));
   endsequence
   a_width_div: assert property (s_steady |->
      roi_width_binned == dv($past(roi_width), horizontal_bin_factor)) else $error("binned width wrong");
   a_row_div: assert property (s_steady |->
      roi_start_row_binned == dv($past(roi_start_row), vertical_bin_factor)) else $error("binned row wrong");
   a_mode_refused: assert property (s_mode_moved |=> config_ignored)
      else $error("mode change not flagged");
   a_ignore_clear: assert property (!acquire |=> !config_ignored)
      else $error("ignore flag while stopped");
   a_byte_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
      else $error("offered byte not held");
   a_ready_empty: assert property (!out_valid |-> pix_ready)
      else $error("pixel refused when empty");
   a_max_fixed: assert property (packet_size_max == 16'(PKT_MAX))
      else $error("packet maximum wrong");
   a_min_clamp: assert property (packet_size_min <= 16'(PKT_MAX))
      else $error("packet minimum too big");
endmodule // pbof_checker
bind pixel_binning_output_formatter pbof_checker #(.PKT_MAX(PKT_MAX)) chk (.*);
`default_nettype wire

// ### tb/pixel_binning_output_formatter_tb.sv
`default_nettype none
module pixel_binning_output_formatter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pixfmt_pkg::*;
   logic sys_clk = '0, rst = '1, stall = '0, pix_valid = '0, pix_frame_start = '0;
   logic pix_line_end = '0, acquire = '0, colour_sensor = '0;
   logic pix_ready, fe, ci, plu, out_valid, out_ready, seen;
   logic [OUT_W-1:0] pix_sample = 16'h0000;
   video_mode_type video_mode = mode_normal;
   pixel_format_type pixel_format = luma_word_format;
   logic [CW_W-1:0] cw = 5'h10;
   logic [BIN_W-1:0] hf = 3'h1, vf = 3'h1;
   logic [ROI_W-1:0] roi[5] = '{14'd16, 14'd1536, 14'd21, 14'd1024, 14'd7};
   logic [ROI_W-1:0] bin[5];
   logic [PKT_W-1:0] pmin, pmax;
   logic [BYTE_W-1:0] out_byte;
   logic [2:0] ft[5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h7};
   logic [5:0] okm[4] = '{6'h03, 6'h30, 6'h0e, 6'h20};
   int cwl[3] = '{16, 12, 10};
   pixel_format_type fl[4] = '{luma_byte_format, luma_word_format, raw_byte_format, raw_word_format};
   int mismatches = 0;
   int checks_done = 0;

   always #25 sys_clk = ~sys_clk;

   pixel_binning_output_formatter uut (.sys_clk, .rst, .pix_sample, .pix_valid, .pix_frame_start, .pix_line_end,
      .pix_ready, .acquire, .colour_sensor, .video_mode, .pixel_format, .converter_sample_width(cw),
      .horizontal_bin_factor(hf), .vertical_bin_factor(vf), .roi_start_col(roi[0]), .roi_width(roi[1]),
      .roi_start_row(roi[2]), .roi_height(roi[3]), .roi_height_step(roi[4]), .roi_start_col_binned(bin[0]),
      .roi_width_binned(bin[1]), .roi_start_row_binned(bin[2]), .roi_height_binned(bin[3]),
      .roi_height_step_binned(bin[4]), .format_error(fe), .config_ignored(ci), .packet_size_min(pmin),
      .packet_size_max(pmax), .packet_limits_update(plu), .out_byte, .out_valid, .out_ready);
   usb_host_sink host (.sys_clk, .out_byte, .out_valid, .out_ready, .stall);

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic cfg(input logic c, video_mode_type m, pixel_format_type f, logic [4:0] w, logic [2:0] h, v);
      colour_sensor = c;
      video_mode = m;
      pixel_format = f;
      cw = w;
      hf = h;
      vf = v;
      tick(6);
   endtask
   task automatic px(input logic [15:0] s, input logic fs, le);
      int i;
      pix_sample = s;
      pix_frame_start = fs;
      pix_line_end = le;
      pix_valid = 1'b1;
      for (i = 0; i < 100 && pix_ready !== 1'b1; i++) tick(1);
      if (i == 100) begin
         mismatches++;
         wrap_up();
      end
      tick(1);
   endtask
   task automatic idle;
      pix_valid = 1'b0;
      pix_frame_start = 1'b0;
      pix_line_end = 1'b0;
   endtask
   task automatic expect_bytes(input logic [95:0] e, input int n, input bit chk);
      int i;
      for (i = 0; i < 200 && host.rx.size() < n; i++) tick(1);
      tick(4);
      cmp(host.rx.size(), n);
      if (i == 200) wrap_up();
      for (i = 0; chk && i < n && i < host.rx.size(); i++) cmp(host.rx[i], e[8*i+:8]);
      host.rx.delete();
   endtask
   function automatic int ef(input logic [2:0] f);
      return (f == 3'h0) ? 1 : int'(f);
   endfunction
   task automatic t_geometry;
      int i, k;
      for (i = 0; i < 5; i++) begin
         cfg(1'b0, mode_normal, luma_word_format, 5'h10, ft[i], ft[(i + 1) % 5]);
         for (k = 0; k < 5; k++) cmp(bin[k], roi[k] / ef((k < 2) ? hf : vf));
      end
   endtask
   task automatic t_luma;
      int i, c;
      logic [15:0] a;
      for (i = 0; i < 4; i++) for (c = 0; c < 3; c++) begin
         a = 16'habcd & (16'hffff << (16 - cwl[c]));
         cfg(1'b0, video_mode_type'(i >= 2), fl[i], 5'(cwl[c]), 3'h1, 3'h1);
         px(16'(a >> (16 - cwl[c])), 1'b1, 1'b1);
         idle();
         expect_bytes(i[0] ? 96'(a) : 96'(a[15:8]), i[0] ? 2 : 1, 1'b1);
      end
   endtask
   task automatic t_sums;
      cfg(1'b0, mode_normal, luma_word_format, 5'h10, 3'h2, 3'h1);
      px(16'h1000, 1'b1, 1'b0);
      px(16'h0234, 1'b0, 1'b0);
      px(16'h5555, 1'b0, 1'b1);
      px(16'hf000, 1'b1, 1'b0);
      px(16'h2000, 1'b0, 1'b1);
      idle();
      expect_bytes(96'hffff1234, 4, 1'b1);
      cfg(1'b0, mode_normal, luma_word_format, 5'h10, 3'h1, 3'h2);
      px(16'h0100, 1'b1, 1'b1);
      px(16'h2000, 1'b0, 1'b1);
      idle();
      expect_bytes(96'h2100, 2, 1'b1);
   endtask
   task automatic t_colour;
      int k;
      cfg(1'b1, mode_raw, raw_word_format, 5'h10, 3'h2, 3'h1);
      px(16'h0100, 1'b1, 1'b0);
      px(16'h0020, 1'b0, 1'b0);
      px(16'h1000, 1'b0, 1'b0);
      px(16'h0003, 1'b0, 1'b1);
      idle();
      expect_bytes(96'h00231100, 4, 1'b1);
      stall = 1'b1;
      for (k = 0; k < 4; k++) begin
         cfg(1'b1, mode_normal, (k < 2) ? rgb_triple_format : yuv_pair_format, 5'h10, 3'h1, 3'h1);
         px(16'h8000, 1'b1, 1'b0);
         px(16'h8000, 1'b0, 1'b1);
         px(16'h8000, 1'b0, 1'b0);
         px(16'h8000, 1'b0, 1'b1);
         idle();
         expect_bytes({12{8'h80}}, (k < 2) ? 12 : 8, k[0]);
      end
      stall = 1'b0;
   endtask
   task automatic t_format;
      int c, m, f;
      for (c = 0; c < 2; c++) for (m = 0; m < 2; m++) for (f = 0; f < 6; f++) begin
         cfg(c[0], video_mode_type'(m[0]), pixel_format_type'(f[2:0]), 5'h10, 3'h1, 3'h1);
         cmp(fe, !okm[c * 2 + m][f]);
      end
      cfg(1'b0, mode_raw, luma_word_format, 5'h10, 3'h1, 3'h1);
      px(16'h1234, 1'b1, 1'b1);
      idle();
      expect_bytes(96'h0, 0, 1'b0);
   endtask
   task automatic t_packet;
      roi[1] = 14'd1024;
      cfg(1'b0, mode_normal, luma_byte_format, 5'h08, 3'h1, 3'h1);
      cmp(pmin, 32);
      cw = 5'h10;
      seen = 1'b0;
      repeat (6) begin
         tick(1);
         seen = seen | plu;
      end
      cmp(seen, 1);
      cmp(pmin, 16);
      roi[1] = 14'd2048;
      cfg(1'b0, mode_normal, luma_word_format, 5'h08, 3'h1, 3'h1);
      cmp(pmin, 48);
      cmp(pmax, 48);
   endtask
   task automatic t_acquire;
      acquire = 1'b1;
      tick(1);
      video_mode = mode_raw;
      cw = 5'h10;
      tick(4);
      cmp(ci, 1);
      cmp(pmin, 48);
      cmp(fe, 0);
      acquire = 1'b0;
      tick(3);
      cmp(ci, 0);
   endtask

   initial begin
      tick(16);
      rst = 1'b0;
      tick(1);
      t_geometry();
      t_luma();
      t_sums();
      t_colour();
      t_format();
      t_packet();
      t_acquire();
      wrap_up();
   end
endmodule // pixel_binning_output_formatter_tb
`default_nettype wire

// ### tb/usb_host_sink.sv
`default_nettype none
module usb_host_sink (
   // Clock and byte stream
   input wire logic       sys_clk,
   input wire logic [7:0] out_byte,
   input wire logic       out_valid,
   output logic           out_ready,
   // Stall control
   input wire logic       stall
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx[$];
   logic       toggle_q = 1'b0;
   // Stalled, the host is ready only every other cycle
   always @(posedge sys_clk) begin
      toggle_q <= !toggle_q;
      if (out_valid && out_ready) rx.push_back(out_byte);
   end
   assign out_ready = !stall || toggle_q;
endmodule // usb_host_sink
`default_nettype wire
